// ---- pkg/vsc_pkg.sv ----
// Purpose: Shared constants and carriers for the vector status and control block.
// Assumes: SystemVerilog bit 0 is the least significant bit of every vector.
// Notes:   Big-endian bit b of a w-bit word sits at SystemVerilog bit w-1-b.
package vsc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths and field positions (SystemVerilog numbering).
    localparam int          VSC_W        = 32;
    localparam int          VEC_W        = 128;
    localparam int          LANES        = 4;
    localparam int          LANE_W       = 32;
    localparam int          WIDE_W       = 34;
    localparam int          CNT_W        = 4;
    localparam int          MAX_INFLIGHT = 8;
    // Big-endian bit 15 is the flush mode, bit 31 the saturation flag.
    localparam int          FLUSH_POS    = 16;
    localparam int          SAT_POS      = 0;
    localparam logic [31:0] VSC_RESET    = 32'h0000_0000;
    localparam logic [95:0] UPPER_ZERO   = 96'h0;
    // Single-precision float layout.
    localparam int          FP_SIGN      = 31;
    localparam int          FP_EXP_HI    = 30;
    localparam int          FP_EXP_LO    = 23;
    localparam int          FP_MAN_HI    = 22;

    ////////////////////////////////////////////////////////////////////////////
    // Floating-point operand bundle for one vector operation.
    typedef struct packed {
        logic [VEC_W-1:0] src;
        logic [VEC_W-1:0] res;
        logic [LANES-1:0] uflow;
    } vsc_fp_t;

    // Saturating operation result bundle: one wide intermediate per lane.
    typedef struct packed {
        logic [LANES*WIDE_W-1:0] wide;
        logic                    unsigned_type;
    } vsc_sat_t;

endpackage : vsc_pkg

// ---- src/vsc_flush.sv ----
// Purpose: Denormal flush of sources and underflowed results, four float lanes.
// Assumes: Purely combinational; the caller registers the outputs.
// Notes:   With the mode clear the data passes through untouched.
module vsc_flush
    import vsc_pkg::*;
(
    input  wire logic             flush_mode_in, // Flush-to-zero mode select.
    input  wire vsc_fp_t          fp_in,         // Raw sources, results, underflows.
    output logic      [VEC_W-1:0] src_out,       // Sources after flushing.
    output logic      [VEC_W-1:0] res_out        // Results after flushing.
);

    ////////////////////////////////////////////////////////////////////////////
    // Zero exponent with a non-zero fraction marks a denormal.
    function automatic logic is_denorm(input logic [LANE_W-1:0] f);
        is_denorm = (f[FP_EXP_HI:FP_EXP_LO] == 8'h00) && (f[FP_MAN_HI:0] != 23'h0);
    endfunction : is_denorm

    // Signed zero keeps only the sign of the original value.
    function automatic logic [LANE_W-1:0] signed_zero(input logic [LANE_W-1:0] f);
        signed_zero = {f[FP_SIGN], 31'h0};
    endfunction : signed_zero

    ////////////////////////////////////////////////////////////////////////////
    // Per-lane flush; lanes are independent so no ordering matters here.
    always_comb begin
        src_out = fp_in.src;
        res_out = fp_in.res;
        for (int i = 0; i < LANES; i++) begin
            if (flush_mode_in) begin
                if (is_denorm(fp_in.src[i*LANE_W +: LANE_W])) begin
                    src_out[i*LANE_W +: LANE_W] = signed_zero(fp_in.src[i*LANE_W +: LANE_W]);
                end
                if (fp_in.uflow[i]) begin
                    res_out[i*LANE_W +: LANE_W] = signed_zero(fp_in.res[i*LANE_W +: LANE_W]);
                end
            end
        end
    end

endmodule : vsc_flush

// ---- src/vsc_saturate.sv ----
// Purpose: Clamp wide per-lane intermediates to a 32-bit signed or unsigned element.
// Assumes: Inputs are signed two's complement, WIDE_W bits per lane.
// Notes:   sat_any_out is high when any lane had to be clamped.
module vsc_saturate
    import vsc_pkg::*;
#(
    parameter int IN_W  = WIDE_W,
    parameter int OUT_W = LANE_W
) (
    input  wire vsc_sat_t           sat_in,      // Wide values and element type.
    output logic [LANES*OUT_W-1:0]  clamp_out,   // Clamped lane values.
    output logic                    sat_any_out  // Some lane saturated.
);

    // Two extra bits are needed to tell unsigned overflow from negatives.
    if (IN_W != WIDE_W || IN_W < OUT_W + 2) begin : g_bad_width
        $error("vsc_saturate: IN_W must equal WIDE_W and exceed OUT_W by two");
    end

    localparam logic signed [IN_W-1:0] S_MAX = IN_W'((64'sd1 <<< (OUT_W-1)) - 1);
    localparam logic signed [IN_W-1:0] S_MIN = -IN_W'(64'sd1 <<< (OUT_W-1));
    localparam logic signed [IN_W-1:0] U_MAX = IN_W'((64'sd1 <<< OUT_W) - 1);

    ////////////////////////////////////////////////////////////////////////////
    // clamp to type range.
    always_comb begin
        logic signed [IN_W-1:0] v;
        logic signed [IN_W-1:0] lo;
        logic signed [IN_W-1:0] hi;
        v = '0;
        lo = sat_in.unsigned_type ? '0 : S_MIN;
        hi = sat_in.unsigned_type ? U_MAX : S_MAX;
        sat_any_out = 1'b0;
        clamp_out = '0;
        for (int i = 0; i < LANES; i++) begin
            v = sat_in.wide[i*IN_W +: IN_W];
            if (v > hi) begin
                clamp_out[i*OUT_W +: OUT_W] = hi[OUT_W-1:0];
                sat_any_out = 1'b1;
            end else if (v < lo) begin
                clamp_out[i*OUT_W +: OUT_W] = lo[OUT_W-1:0];
                sat_any_out = 1'b1;
            end else begin
                clamp_out[i*OUT_W +: OUT_W] = v[OUT_W-1:0];
            end
        end
    end

endmodule : vsc_saturate

// ---- src/vsc_top.sv ----
// Purpose: Vector status and control register with precise copy-out,
//          denormal flush path and saturation path of the vector unit.
// Assumes: Saturating operations complete in issue order; one read at a time.
// Notes:   Writes are refused while a copy-out is waiting (busy_out high).

// Function
// - 32-bit register, flush bit 15, sticky bit 31
// - reserved bits read back last written value
// - flush mode 0: denormals handled unflushed
// - flush mode 1: denormal sources become signed zero
// - flush mode 1: underflowed results become signed zero
// - any saturated lane sets sticky bit, stays
// - sticky bit cleared only by explicit write
// - saturation clamps to element type range
// - copy right-justified, upper 96 bits zero
// - halfword elements 6 and 7 hold register
// - copy reflects exactly the older saturation updates
// - byte element 0 is most significant
module vsc_top
    import vsc_pkg::*;
(
    input  wire logic             clk_in,          // Core clock, 125 MHz.
    input  wire logic             rst_n_in,        // Synchronous reset, active low.
    input  wire logic             wr_valid_in,     // Write register from vector.
    input  wire logic [VEC_W-1:0] wr_data_in,      // Source vector of the write.
    input  wire logic             rd_req_in,       // Copy register to a vector.
    input  wire logic             sat_issue_in,    // Saturating op issued.
    input  wire logic             sat_valid_in,    // Saturating op completes.
    input  wire vsc_sat_t         sat_in,          // Its wide lane values.
    input  wire logic             fp_valid_in,     // Float op operands valid.
    input  wire vsc_fp_t          fp_in,           // Float sources and results.
    output logic                  busy_out,        // Copy-out waiting.
    output logic                  rd_valid_out,    // Copy-out result valid.
    output logic      [VEC_W-1:0] rd_data_out,     // Copied vector.
    output logic                  sat_valid_out,   // Clamped result valid.
    output logic      [VEC_W-1:0] sat_data_out,    // Clamped result.
    output logic                  fp_valid_out,    // Flushed float data valid.
    output logic      [VEC_W-1:0] fp_src_out,      // Flushed sources.
    output logic      [VEC_W-1:0] fp_res_out,      // Flushed results.
    output logic                  flush_mode_out,  // Current flush mode.
    output logic                  sat_sticky_out   // Current sticky flag.
);

    if (MAX_INFLIGHT >= (1 << CNT_W)) begin : g_bad_count
        $error("vsc_top: MAX_INFLIGHT does not fit CNT_W");
    end

    ////////////////////////////////////////////////////////////////////////////
    // All state of the block.
    typedef struct packed {
        logic [VSC_W-1:0] vector_status_control;
        logic [CNT_W-1:0] inflight;
        logic [CNT_W-1:0] wait_cnt;
        logic             rd_pend;
        logic             rd_valid;
        logic [VEC_W-1:0] rd_data;
        logic             sat_valid;
        logic [VEC_W-1:0] sat_data;
        logic             fp_valid;
        logic [VEC_W-1:0] fp_src;
        logic [VEC_W-1:0] fp_res;
    } vsc_state_t;

    vsc_state_t       state_reg;
    vsc_state_t       state_next;
    logic [VEC_W-1:0] flush_src;
    logic [VEC_W-1:0] flush_res;
    logic [VEC_W-1:0] clamp_val;
    logic             sat_any;
    logic             wr_take;
    logic             flush_mode;

    assign flush_mode = state_reg.vector_status_control[FLUSH_POS];
    // explicit write only.
    // Writes are taken only when no copy-out is waiting, so a later write can
    // never leak into a copy that still waits for older operations.
    assign wr_take    = wr_valid_in && !state_reg.rd_pend;

    ////////////////////////////////////////////////////////////////////////////
    // Datapath helpers.
    vsc_flush u_flush (
        .flush_mode_in (flush_mode),
        .fp_in         (fp_in),
        .src_out       (flush_src),
        .res_out       (flush_res)
    );

    vsc_saturate #(
        .IN_W  (WIDE_W),
        .OUT_W (LANE_W)
    ) u_saturate (
        .sat_in      (sat_in),
        .clamp_out   (clamp_val),
        .sat_any_out (sat_any)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        state_next = state_reg;
        state_next.rd_valid  = 1'b0;
        state_next.sat_valid = sat_valid_in;
        state_next.fp_valid  = fp_valid_in;
        if (fp_valid_in) begin
            state_next.fp_src = flush_src;
            state_next.fp_res = flush_res;
        end
        if (sat_valid_in) begin
            state_next.sat_data = clamp_val;
        end
        if (wr_take) begin
            state_next.vector_status_control = wr_data_in[VSC_W-1:0];
        end
        if (sat_valid_in && sat_any) begin
            state_next.vector_status_control[SAT_POS] = 1'b1;
        end
        // In-flight count of saturating ops.
        state_next.inflight = state_reg.inflight + CNT_W'(sat_issue_in)
                              - CNT_W'(sat_valid_in);
        if (state_reg.rd_pend) begin
            if (state_reg.wait_cnt == '0) begin
                state_next.rd_pend  = 1'b0;
                state_next.rd_valid = 1'b1;
                // byte 0 lands in the top bits.
                state_next.rd_data  = {UPPER_ZERO, state_reg.vector_status_control};
            end else if (sat_valid_in) begin
                state_next.wait_cnt = state_reg.wait_cnt - CNT_W'(1);
            end
        end else if (rd_req_in) begin
            // snapshot older ops only.
            // A completion in the request cycle is already in the register
            // at the next edge, so it is not waited for again.
            state_next.rd_pend  = 1'b1;
            state_next.wait_cnt = state_reg.inflight - CNT_W'(sat_valid_in);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg <= '0;
            state_reg.vector_status_control <= VSC_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register.
    assign busy_out       = state_reg.rd_pend;
    assign rd_valid_out   = state_reg.rd_valid;
    assign rd_data_out    = state_reg.rd_data;
    assign sat_valid_out  = state_reg.sat_valid;
    assign sat_data_out   = state_reg.sat_data;
    assign fp_valid_out   = state_reg.fp_valid;
    assign fp_src_out     = state_reg.fp_src;
    assign fp_res_out     = state_reg.fp_res;
    assign flush_mode_out = flush_mode;
    assign sat_sticky_out = state_reg.vector_status_control[SAT_POS];

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    logic lane0_denorm;
    assign lane0_denorm = (fp_in.src[FP_EXP_HI:FP_EXP_LO] == 8'h00)
                          && (fp_in.src[FP_MAN_HI:0] != 23'h0);

    // Copy-out is due: no older saturating op is left to wait for.
    sequence seq_ready;
        state_reg.rd_pend && (state_reg.wait_cnt == '0);
    endsequence

    // Answer carries the register as it stood one edge earlier.
    sequence seq_answer;
        rd_valid_out && (rd_data_out[VSC_W-1:0] == $past(state_reg.vector_status_control));
    endsequence

    // Request taken with nothing in flight: the short path.
    sequence seq_request;
        rd_req_in && !state_reg.rd_pend && (state_reg.inflight == '0);
    endsequence

    chk_copy_on_ready: assert property (seq_ready |=> seq_answer)
        else $error("copy-out not answered when older ops done");

    chk_copy_latency: assert property (seq_request |=> busy_out ##1 seq_answer)
        else $error("idle copy-out not answered two cycles after request");

    chk_upper_zero: assert property (rd_valid_out |-> rd_data_out[VEC_W-1:VSC_W] == '0)
        else $error("copied vector upper 96 bits not zero");

    chk_no_early_copy: assert property (
        busy_out && (state_reg.wait_cnt != '0) |=> !rd_valid_out)
        else $error("copy-out answered before older ops finished");

    chk_sat_set: assert property (sat_valid_in && sat_any |=> sat_sticky_out)
        else $error("saturation did not set sticky flag");

    chk_sat_hold: assert property (sat_sticky_out && !wr_take |=> sat_sticky_out)
        else $error("sticky flag cleared without a write");

    chk_write_low: assert property (wr_take && !(sat_valid_in && sat_any)
        |=> state_reg.vector_status_control == $past(wr_data_in[VSC_W-1:0]))
        else $error("write did not load low word");

    chk_flush_mode: assert property (
        wr_take |=> flush_mode_out == $past(wr_data_in[FLUSH_POS]))
        else $error("flush mode not at its field");

    chk_src_flush: assert property (fp_valid_in && flush_mode && lane0_denorm
        |=> fp_valid_out && fp_src_out[FP_SIGN-1:0] == '0
        && fp_src_out[FP_SIGN] == $past(fp_in.src[FP_SIGN]))
        else $error("denormal source not flushed");

    chk_res_flush: assert property (fp_valid_in && flush_mode && fp_in.uflow[0]
        |=> fp_res_out[LANE_W-1:0] == {$past(fp_in.res[FP_SIGN]), 31'h0})
        else $error("underflowed result not signed zero");

    chk_no_flush: assert property (fp_valid_in && !flush_mode
        |=> fp_src_out == $past(fp_in.src) && fp_res_out == $past(fp_in.res))
        else $error("data altered in compliant mode");

    chk_clamp_max: assert property (sat_valid_in && !sat_in.unsigned_type
        && $signed(sat_in.wide[WIDE_W-1:0]) > $signed(34'sh0_7fff_ffff)
        |=> sat_data_out[LANE_W-1:0] == 32'h7fff_ffff && sat_sticky_out)
        else $error("signed overflow not clamped to maximum");

    chk_clamp_min: assert property (sat_valid_in && !sat_in.unsigned_type
        && $signed(sat_in.wide[2*WIDE_W-1:WIDE_W]) < $signed(34'sh3_8000_0000)
        |=> sat_data_out[2*LANE_W-1:LANE_W] == 32'h8000_0000 && sat_sticky_out)
        else $error("signed underflow not clamped to minimum");

    chk_clamp_umax: assert property (sat_valid_in && sat_in.unsigned_type
        && $signed(sat_in.wide[WIDE_W-1:0]) > $signed(34'sh0_ffff_ffff)
        |=> sat_data_out[LANE_W-1:0] == 32'hffff_ffff && sat_sticky_out)
        else $error("unsigned overflow not clamped to maximum");

    chk_sat_answer: assert property (sat_valid_in |=> sat_valid_out)
        else $error("clamped result not valid one cycle on");

    chk_fp_answer: assert property (fp_valid_in |=> fp_valid_out)
        else $error("float data not valid one cycle on");

    // set wins over clear.
    // A saturation in the cycle of a clearing write must not be lost.
    chk_set_wins: assert property (wr_take && sat_valid_in && sat_any
        |=> sat_sticky_out)
        else $error("clearing write hid a saturation");

    // halfword placement.
    // Halfword six holds the flush mode half, halfword seven the sticky half.
    chk_copy_halves: assert property (rd_valid_out
        |-> rd_data_out[VSC_W-1:VSC_W/2]
            == $past(state_reg.vector_status_control[VSC_W-1:VSC_W/2])
        && rd_data_out[VSC_W/2-1:0]
            == $past(state_reg.vector_status_control[VSC_W/2-1:0]))
        else $error("copied halfwords out of place");

    chk_byte_order: assert property (rd_valid_out
        |-> rd_data_out[VEC_W-1 -: 8] == 8'h00
        && rd_data_out[7:0] == $past(state_reg.vector_status_control[7:0]))
        else $error("byte elements not in big-endian order");

    chk_write_refused: assert property (busy_out && wr_valid_in
        && !(sat_valid_in && sat_any)
        |=> $stable(state_reg.vector_status_control))
        else $error("write taken while a copy-out was waiting");

    // wait count bounded.
    // The copy may only wait for operations that are really in flight.
    chk_wait_bound: assert property (busy_out
        |-> state_reg.wait_cnt <= state_reg.inflight)
        else $error("copy-out waits for more ops than are in flight");

    chk_inflight_cap: assert property (state_reg.inflight <= CNT_W'(MAX_INFLIGHT))
        else $error("in-flight count above its ceiling");

    chk_answer_pulse: assert property (rd_valid_out
        |-> !busy_out ##1 !rd_valid_out)
        else $error("copy-out answer longer than one cycle");

endmodule : vsc_top

// ---- testbench/vsc_partner.sv ----
// Purpose: Far-side model of the vector unit: issues and completes operations.
// Assumes: Completions come in issue order, never more than MAX_INFLIGHT pending.
// Notes:   Released data lines show the inverse of their last value.
module vsc_partner
    import vsc_pkg::*;
(
    input  wire logic clk_in,       // Core clock.
    output logic      issue_out,    // Saturating op issued.
    output logic      done_out,     // Oldest saturating op completes.
    output vsc_sat_t  sat_out,      // Wide lane values.
    output logic      fp_valid_out, // Float operands valid.
    output vsc_fp_t   fp_out        // Float sources and results.
);
    timeunit 1ns;
    timeprecision 1ps;

    int inflight = 0;

    // Quiet bus at time zero.
    initial begin
        issue_out = 1'b0;
        done_out = 1'b0;
        fp_valid_out = 1'b0;
        sat_out = '0;
        fp_out = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Issue one saturating op; the in-flight ceiling is never passed.
    task automatic issue();
        @(negedge clk_in);
        if (inflight < MAX_INFLIGHT) begin
            issue_out = 1'b1;
            inflight++;
        end
        @(negedge clk_in);
        issue_out = 1'b0;
    endtask : issue

    // Complete the oldest op; nothing completes that was not issued.
    task automatic complete(input logic [LANES*WIDE_W-1:0] wide, input logic uns);
        @(negedge clk_in);
        if (inflight > 0) begin
            done_out = 1'b1;
            sat_out = '{wide: wide, unsigned_type: uns};
            inflight--;
        end
        @(negedge clk_in);
        done_out = 1'b0;
        sat_out = vsc_sat_t'(~sat_out);
    endtask : complete

    // Present one float operation for a single cycle.
    task automatic fp_op(input vsc_fp_t v);
        @(negedge clk_in);
        fp_valid_out = 1'b1;
        fp_out = v;
        @(negedge clk_in);
        fp_valid_out = 1'b0;
        fp_out = vsc_fp_t'(~fp_out);
    endtask : fp_op

endmodule : vsc_partner

// ---- testbench/vsc_top_test.sv ----
// Purpose: Self-checking bench for the vector status and control register.
// Assumes: Inputs change on the falling clock edge only.
// Notes:   Upper write bits carry junk to show that only the low word loads.
module vsc_top_test
    import vsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [135:0] SAT_S = {34'h3_ffff_ffff, 34'h0_0000_0005,
                                      34'h3_7fff_ffff, 34'h0_8000_0000};
    localparam logic [135:0] SAT_U = {34'h0_ffff_ffff, 34'h0_0000_0005,
                                      34'h3_ffff_ffff, 34'h1_0000_0000};
    localparam logic [135:0] NO_SAT = {4{34'h0_0000_0007}};
    localparam vsc_fp_t FP_V = '{src: {32'h0, 32'h3f80_0000, 32'h0000_0010, 32'h8000_0001},
                                 res: {32'h3f00_0000, 32'h0000_0abc, 32'h4000_0000,
                                       32'h8000_1234}, uflow: 4'h5};

    logic             clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             wr_valid = 1'b0;
    logic [VEC_W-1:0] wr_data = '0;
    logic             rd_req = 1'b0;
    logic             issue, done, fp_valid, busy, rd_valid, sat_valid, fpv, flush, sticky;
    vsc_sat_t         saturation_sticky;
    vsc_fp_t          fp;
    logic [VEC_W-1:0] rd_data, sat_data, fp_src, fp_res, d;
    int               n_errors = 0;
    int               n_tests = 0;
    int               cycles = 0;

    // Clock of 8 ns period.
    always #4 clk = ~clk;

    vsc_partner u_vsc_partner (.clk_in(clk), .issue_out(issue), .done_out(done),
        .sat_out(saturation_sticky), .fp_valid_out(fp_valid), .fp_out(fp));

    vsc_top u_vsc_top (.clk_in(clk), .rst_n_in(rst_n), .wr_valid_in(wr_valid),
        .wr_data_in(wr_data), .rd_req_in(rd_req), .sat_issue_in(issue),
        .sat_valid_in(done), .sat_in(saturation_sticky), .fp_valid_in(fp_valid), .fp_in(fp),
        .busy_out(busy), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
        .sat_valid_out(sat_valid), .sat_data_out(sat_data), .fp_valid_out(fpv),
        .fp_src_out(fp_src), .fp_res_out(fp_res), .flush_mode_out(flush),
        .sat_sticky_out(sticky));

    ////////////////////////////////////////////////////////////////////////////
    // Verdict, reached from the main sequence or the hang guard.
    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // Cut a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Write the register from a vector whose upper bits are junk.
    task automatic write(input logic [31:0] w);
        @(negedge clk);
        wr_valid = 1'b1;
        wr_data = {96'ha5a5_5a5a_ffff_0000_1234_5678, w};
        @(negedge clk);
        wr_valid = 1'b0;
    endtask : write

    task automatic start_copy();
        @(negedge clk);
        rd_req = 1'b1;
        @(negedge clk);
        rd_req = 1'b0;
    endtask : start_copy

    // Wait a bounded time for the copy-out answer.
    task automatic wait_copy(output logic [127:0] v);
        for (int i = 0; i < 20 && rd_valid !== 1'b1; i++) @(negedge clk);
        check(128'(rd_valid), 128'h1);
        v = rd_data;
    endtask : wait_copy

    task automatic run_sat(input logic [135:0] w, input logic uns, input logic [127:0] exp);
        u_vsc_partner.issue();
        u_vsc_partner.complete(w, uns);
        check(128'(sat_valid), 128'h1);
        check(sat_data, exp);
    endtask : run_sat

    task automatic run_fp(input logic on);
        u_vsc_partner.fp_op(FP_V);
        check(128'(fpv), 128'h1);
        check(fp_src, on ? {32'h0, 32'h3f80_0000, 32'h0, 32'h8000_0000} : FP_V.src);
        check(fp_res, on ? {32'h3f00_0000, 32'h0, 32'h4000_0000, 32'h8000_0000} : FP_V.res);
    endtask : run_fp

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        check(128'({busy, rd_valid, flush, sticky}), 128'h0);
        // low word loads the flush mode
        write(32'h0001_0000);
        check(128'({flush, sticky}), 128'h2);
        start_copy();
        wait_copy(d);
        check(d, {96'h0, 32'h0001_0000});
        check(128'(d[31:16]), 128'h1);
        run_fp(1'b1);
        write(32'h0);
        run_fp(1'b0);
        // reserved bits written zero read zero
        start_copy();
        wait_copy(d);
        check(d, 128'h0);
        run_sat(SAT_S, 1'b0, {32'hffff_ffff, 32'h5, 32'h8000_0000, 32'h7fff_ffff});
        check(128'(sticky), 128'h1);
        run_sat(SAT_U, 1'b1, {32'hffff_ffff, 32'h5, 32'h0, 32'hffff_ffff});
        run_sat(NO_SAT, 1'b0, {4{32'h7}});
        check(128'(sticky), 128'h1);
        start_copy();
        wait_copy(d);
        check(128'(d[7:0]), 128'h1);
        write(32'h0);
        check(128'(sticky), 128'h0);
        // saturation beats a clearing write in the same cycle.
        u_vsc_partner.issue();
        fork
            u_vsc_partner.complete(SAT_S, 1'b0);
            write(32'h0);
        join
        check(128'(sticky), 128'h1);
        write(32'h0);
        // copy waits for older saturating ops
        u_vsc_partner.issue();
        u_vsc_partner.issue();
        start_copy();
        check(128'({busy, rd_valid}), 128'h2);
        // A write while the copy waits is dropped.
        write(32'h0001_0000);
        check(128'({busy, flush}), 128'h2);
        u_vsc_partner.complete(SAT_S, 1'b0);
        check(128'({busy, rd_valid}), 128'h2);
        u_vsc_partner.complete(NO_SAT, 1'b0);
        wait_copy(d);
        check(d, {96'h0, 32'h1});
        print_verdict();
    end

endmodule : vsc_top_test
